// *** shared/csb_pkg.sv ***
// Shared types and constants for the compare, skip and flag-branch unit.
package csb_pkg;
    // ==========================================================
    // Status flag positions
    localparam int FLAG_C = 0;
    localparam int FLAG_Z = 1;
    localparam int FLAG_N = 2;
    localparam int FLAG_V = 3;
    localparam int FLAG_S = 4;
    localparam int FLAG_H = 5;
    localparam int FLAG_T = 6;
    localparam int FLAG_I = 7;
    // ==========================================================
    // Widths, reset values and cycle figures
    localparam int DATA_W = 8;
    localparam int PC_W = 16;
    localparam int OFS_W = 7;
    localparam logic [15:0] PC_RESET = 16'h0000;
    localparam logic [1:0] CYC_NO_SKIP = 2'h1;
    localparam logic [1:0] CYC_SKIP_ONE = 2'h2;
    localparam logic [1:0] CYC_SKIP_TWO = 2'h3;
    localparam logic [15:0] STEP_ONE = 16'h0001;
    localparam logic [15:0] STEP_SKIP_ONE = 16'h0002;
    localparam logic [15:0] STEP_SKIP_TWO = 16'h0003;
    // ==========================================================
    // Operations
    typedef enum logic [2:0] {
        OP_NONE,
        OP_COMPARE,
        OP_COMPARE_CARRY,
        OP_COMPARE_IMM,
        OP_SKIP_REG_BIT_CLEAR,
        OP_SKIP_REG_BIT_SET,
        OP_SKIP_IO_BIT_CLEAR,
        OP_SKIP_IO_BIT_SET
    } csb_op_type;
    // ==========================================================
    // Decoded instruction carrier
    typedef struct packed {
        logic valid;
        csb_op_type op;
        logic branch;
        logic [7:0] dest_value;
        logic [7:0] source_value;
        logic [7:0] immediate;
        logic [2:0] bit_sel;
        logic [6:0] offset;
        logic next_is_two_word;
    } csb_instr_type;
endpackage

// *** hdl/csb_flag_alu.sv ***
// Subtract-and-flag datapath shared by the three compare forms.
`timescale 1ns/10ps
module csb_flag_alu (
    // Operands
    input wire logic [7:0] minuend_in,
    input wire logic [7:0] subtrahend_in,
    input wire logic borrow_in,
    input wire logic zero_prev_in,
    input wire logic chain_zero_in,
    // Flags
    output logic zero_out,
    output logic negative_out,
    output logic overflow_out,
    output logic carry_out,
    output logic half_carry_out,
    output logic sign_out
);
    logic [8:0] diff;

    always_comb begin
        diff = {1'b0, minuend_in} - {1'b0, subtrahend_in} - {8'h00, borrow_in};
        negative_out = diff[7];
        overflow_out = (minuend_in[7] & ~subtrahend_in[7] & ~diff[7])
            | (~minuend_in[7] & subtrahend_in[7] & diff[7]);
        carry_out = (~minuend_in[7] & subtrahend_in[7]) | (subtrahend_in[7] & diff[7])
            | (diff[7] & ~minuend_in[7]);
        half_carry_out = (~minuend_in[3] & subtrahend_in[3]) | (subtrahend_in[3] & diff[3])
            | (diff[3] & ~minuend_in[3]);
        sign_out = negative_out ^ overflow_out;
        // The carry form only keeps zero if it was already set, so a multi-byte
        // compare reports zero only when every byte matched.
        if (chain_zero_in) begin
            zero_out = (diff[7:0] == 8'h00) & zero_prev_in;
        end else begin
            zero_out = (diff[7:0] == 8'h00);
        end
    end
endmodule // csb_flag_alu

// *** hdl/csb_unit.sv ***
// Execution of compare, bit-test skip and flag-set branch instructions.
`timescale 1ns/10ps
// Operation
// - Register compare sets flags, one cycle.
// - Compare with carry subtracts carry too.
// - Immediate compare sets flags, one cycle.
// - Skip when register bit is clear.
// - Skip when register bit is set.
// - Skip when I/O bit is clear.
// - Skip when I/O bit is set.
// - Branch to PC plus offset plus one.
module csb_unit (
    // Clock and reset
    input wire logic clk_in,
    input wire logic reset_n_in,
    // Decoded instruction
    input wire csb_pkg::csb_instr_type instr_in,
    output logic instr_ready_out,
    // I/O space bit read
    output logic [2:0] io_bit_sel_out,
    input wire logic [7:0] io_value_in,
    // Status flag register
    output logic [7:0] status_flag_register_out,
    // Program counter
    output logic [15:0] program_counter_out,
    output logic done_out
);
    // ==========================================================
    // State
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_WAIT
    } csb_state_type;

    // The wait counter holds the extra cycles still owed by a taken skip. The
    // new program counter waits in pending_pc_ff until the last of them.
    csb_state_type state_ff, nxt_state;
    logic [7:0] status_flag_register_ff, nxt_status_flag_register;
    logic [15:0] program_counter_ff, nxt_program_counter;
    logic [15:0] pending_pc_ff, nxt_pending_pc;
    logic [1:0] wait_ff, nxt_wait;
    logic done_ff, nxt_done;

    // Flag results of the shared subtractor, valid in the cycle in which the
    // instruction is offered.
    logic zero_flag, negative_flag, overflow_flag, carry_flag, half_flag, sign_flag;
    logic [7:0] subtrahend;
    logic borrow;
    logic is_carry_form;
    logic tested_bit;
    logic skip_taken;
    logic [15:0] offset_ext;

    // One bit picker serves the working register, the I/O value and the flags,
    // so all three tests index their bits the same way.
    function automatic logic select_bit(input logic [7:0] value, input logic [2:0] sel);
        select_bit = value[sel];
    endfunction

    // ==========================================================
    // Compare datapath
    // Only the carry form feeds the old carry in as a borrow, and only the
    // immediate form swaps the source register for the embedded constant.
    always_comb begin
        is_carry_form = (instr_in.op == csb_pkg::OP_COMPARE_CARRY);
        borrow = is_carry_form & status_flag_register_ff[csb_pkg::FLAG_C];
        if (instr_in.op == csb_pkg::OP_COMPARE_IMM) begin
            subtrahend = instr_in.immediate;
        end else begin
            subtrahend = instr_in.source_value;
        end
    end

    csb_flag_alu u_alu (
        .minuend_in(instr_in.dest_value),
        .subtrahend_in(subtrahend),
        .borrow_in(borrow),
        .zero_prev_in(status_flag_register_ff[csb_pkg::FLAG_Z]),
        .chain_zero_in(is_carry_form),
        .zero_out(zero_flag),
        .negative_out(negative_flag),
        .overflow_out(overflow_flag),
        .carry_out(carry_flag),
        .half_carry_out(half_flag),
        .sign_out(sign_flag)
    );

    // The bit select goes straight out so that the I/O space can return the
    // addressed register in the same cycle as the instruction.
    assign io_bit_sel_out = instr_in.bit_sel;
    // Ready drops only while a taken skip spends its extra cycles. An
    // instruction offered then is ignored, not queued.
    assign instr_ready_out = (state_ff == ST_IDLE);

    // ==========================================================
    // Next-state logic
    // Everything defaults to holding, so each branch below names only what it
    // changes, and done falls back to low after one cycle.
    always_comb begin
        nxt_state = state_ff;
        nxt_status_flag_register = status_flag_register_ff;
        nxt_program_counter = program_counter_ff;
        nxt_pending_pc = pending_pc_ff;
        nxt_wait = wait_ff;
        nxt_done = 1'b0;
        tested_bit = 1'b0;
        skip_taken = 1'b0;
        offset_ext = {{9{instr_in.offset[6]}}, instr_in.offset};
        // The branch bit overrides the operation code, so a branch needs no
        // operation of its own. A branch that is not taken still steps over itself.
        case (state_ff)
            ST_IDLE: begin
                if (instr_in.valid && instr_in.branch) begin
                    nxt_done = 1'b1;
                    if (select_bit(status_flag_register_ff, instr_in.bit_sel)) begin
                        nxt_program_counter = program_counter_ff + offset_ext
                            + csb_pkg::STEP_ONE;
                    end else begin
                        nxt_program_counter = program_counter_ff + csb_pkg::STEP_ONE;
                    end
                end else if (instr_in.valid) begin
                    case (instr_in.op)
                        csb_pkg::OP_COMPARE, csb_pkg::OP_COMPARE_CARRY,
                        csb_pkg::OP_COMPARE_IMM: begin
                            nxt_status_flag_register[csb_pkg::FLAG_Z] = zero_flag;
                            nxt_status_flag_register[csb_pkg::FLAG_N] = negative_flag;
                            nxt_status_flag_register[csb_pkg::FLAG_V] = overflow_flag;
                            nxt_status_flag_register[csb_pkg::FLAG_C] = carry_flag;
                            nxt_status_flag_register[csb_pkg::FLAG_H] = half_flag;
                            nxt_status_flag_register[csb_pkg::FLAG_S] = sign_flag;
                            nxt_program_counter = program_counter_ff + csb_pkg::STEP_ONE;
                            nxt_done = 1'b1;
                        end
                        csb_pkg::OP_SKIP_REG_BIT_CLEAR: begin
                            tested_bit = select_bit(instr_in.source_value, instr_in.bit_sel);
                            skip_taken = ~tested_bit;
                        end
                        csb_pkg::OP_SKIP_REG_BIT_SET: begin
                            tested_bit = select_bit(instr_in.source_value, instr_in.bit_sel);
                            skip_taken = tested_bit;
                        end
                        csb_pkg::OP_SKIP_IO_BIT_CLEAR: begin
                            tested_bit = select_bit(io_value_in, instr_in.bit_sel);
                            skip_taken = ~tested_bit;
                        end
                        csb_pkg::OP_SKIP_IO_BIT_SET: begin
                            tested_bit = select_bit(io_value_in, instr_in.bit_sel);
                            skip_taken = tested_bit;
                        end
                        default: begin
                            // An unused operation without the branch bit is dropped.
                            nxt_done = 1'b0;
                        end
                    endcase
                    // All skips share one tail: a skip not taken acts like any
                    // single-cycle instruction, and a taken one parks its target and waits.
                    if (instr_in.op inside {csb_pkg::OP_SKIP_REG_BIT_CLEAR,
                        csb_pkg::OP_SKIP_REG_BIT_SET, csb_pkg::OP_SKIP_IO_BIT_CLEAR,
                        csb_pkg::OP_SKIP_IO_BIT_SET}) begin
                        if (!skip_taken) begin
                            nxt_program_counter = program_counter_ff + csb_pkg::STEP_ONE;
                            nxt_done = 1'b1;
                        end else if (instr_in.next_is_two_word) begin
                            nxt_pending_pc = program_counter_ff + csb_pkg::STEP_SKIP_TWO;
                            nxt_wait = csb_pkg::CYC_SKIP_TWO - csb_pkg::CYC_NO_SKIP;
                            nxt_state = ST_WAIT;
                        end else begin
                            nxt_pending_pc = program_counter_ff + csb_pkg::STEP_SKIP_ONE;
                            nxt_wait = csb_pkg::CYC_SKIP_ONE - csb_pkg::CYC_NO_SKIP;
                            nxt_state = ST_WAIT;
                        end
                    end
                end
            end
            ST_WAIT: begin
                // Flags are left alone here, because a skip never touches them.
                nxt_wait = wait_ff - 2'h1;
                if (wait_ff == 2'h1) begin
                    nxt_program_counter = pending_pc_ff;
                    nxt_done = 1'b1;
                    nxt_state = ST_IDLE;
                end
            end
            default: begin
                nxt_state = ST_IDLE;
            end
        endcase
    end

    // ==========================================================
    // Registers
    // Reset loads constants only, so the flags start cleared and the counter
    // starts at its reset address.
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            state_ff <= ST_IDLE;
            status_flag_register_ff <= 8'h00;
            program_counter_ff <= csb_pkg::PC_RESET;
            pending_pc_ff <= csb_pkg::PC_RESET;
            wait_ff <= 2'h0;
            done_ff <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            status_flag_register_ff <= nxt_status_flag_register;
            program_counter_ff <= nxt_program_counter;
            pending_pc_ff <= nxt_pending_pc;
            wait_ff <= nxt_wait;
            done_ff <= nxt_done;
        end
    end

    // ==========================================================
    // Outputs
    // The flag, counter and done outputs come straight from flip-flops, so done and the program
    // counter change together on one edge.
    assign status_flag_register_out = status_flag_register_ff;
    assign program_counter_out = program_counter_ff;
    assign done_out = done_ff;
endmodule // csb_unit

// *** testbench/csb_unit_chk.sv ***
// Concurrent checks on the ports of the compare, skip and flag-branch unit.
`timescale 1ns/10ps
module csb_unit_chk (
    // Clock and reset
    input wire logic clk_in,
    input wire logic reset_n_in,
    // Observed ports
    input wire csb_pkg::csb_instr_type instr_in,
    input wire logic instr_ready_out,
    input wire logic [2:0] io_bit_sel_out,
    input wire logic [7:0] io_value_in,
    input wire logic [7:0] status_flag_register_out,
    input wire logic [15:0] program_counter_out,
    input wire logic done_out
);
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (!reset_n_in);
    logic take;
    logic rbit;
    logic ibit;
    assign take = instr_in.valid && instr_ready_out && !instr_in.branch;
    assign rbit = instr_in.source_value[instr_in.bit_sel];
    assign ibit = io_value_in[instr_in.bit_sel];
    a_cmp_one_cycle: assert property (take && instr_in.op == csb_pkg::OP_COMPARE |=> done_out
        && status_flag_register_out[1] == ($past(instr_in.dest_value) == $past(instr_in.source_value)))
        else $error("register compare result wrong");
    a_cmpc_one_cycle: assert property (take && instr_in.op == csb_pkg::OP_COMPARE_CARRY
        |=> done_out && program_counter_out == $past(program_counter_out) + 16'h0001)
        else $error("compare with carry timing wrong");
    a_cmpi_flags: assert property (take && instr_in.op == csb_pkg::OP_COMPARE_IMM |=> done_out
        && status_flag_register_out[0] == ($past(instr_in.dest_value) < $past(instr_in.immediate)))
        else $error("immediate compare carry wrong");
    a_reg_clr_skip: assert property (take && instr_in.op == csb_pkg::OP_SKIP_REG_BIT_CLEAR
        && !rbit && !instr_in.next_is_two_word |=> !done_out ##1
        (done_out && program_counter_out == $past(program_counter_out, 2) + 16'h0002))
        else $error("register clear skip wrong");
    a_reg_set_skip: assert property (take && instr_in.op == csb_pkg::OP_SKIP_REG_BIT_SET
        && rbit && instr_in.next_is_two_word |=> !done_out [*2] ##1
        (done_out && program_counter_out == $past(program_counter_out, 3) + 16'h0003))
        else $error("register set skip wrong");
    a_io_clr_noskip: assert property (take && instr_in.op == csb_pkg::OP_SKIP_IO_BIT_CLEAR && ibit
        |=> done_out && program_counter_out == $past(program_counter_out) + 16'h0001
        && $stable(status_flag_register_out)) else $error("io clear skip wrong");
    a_io_set_flags: assert property (take && instr_in.op == csb_pkg::OP_SKIP_IO_BIT_SET && ibit
        |=> $stable(status_flag_register_out) ##1 $stable(status_flag_register_out))
        else $error("io set skip altered flags");
    a_branch_taken: assert property (instr_in.valid && instr_ready_out && instr_in.branch
        && status_flag_register_out[instr_in.bit_sel] |=> done_out && program_counter_out ==
        $past(program_counter_out) + {{9{$past(instr_in.offset[6])}}, $past(instr_in.offset)}
        + 16'h0001) else $error("taken branch target wrong");
    a_wait_no_done: assert property (!instr_ready_out |-> !done_out)
        else $error("done during skip wait");
endmodule // csb_unit_chk
bind csb_unit csb_unit_chk csb_unit_chk_inst (.clk_in(clk_in), .reset_n_in(reset_n_in),
    .instr_in(instr_in), .instr_ready_out(instr_ready_out), .io_bit_sel_out(io_bit_sel_out),
    .io_value_in(io_value_in), .status_flag_register_out(status_flag_register_out),
    .program_counter_out(program_counter_out), .done_out(done_out));

// *** testbench/tb_top.sv ***
// Random self-checking bench for the compare, skip and flag-branch unit.
`timescale 1ns/10ps
module tb_top;
    logic clk_in = 1'b0;
    logic reset_n_in = 1'b0;
    csb_pkg::csb_instr_type instr = '0;
    logic [7:0] io_value = 8'h00;
    logic ready;
    logic [2:0] io_sel;
    logic [7:0] flags;
    logic [15:0] pc;
    logic done;
    int miscompares = 0;
    int n_compared = 0;
    logic [31:0] seed = 32'h00000001;
    logic [15:0] epc = 16'h0000;
    logic [7:0] ef = 8'h00;
    always #25 clk_in = ~clk_in;
    csb_unit csb_unit_inst (.clk_in(clk_in), .reset_n_in(reset_n_in), .instr_in(instr),
        .instr_ready_out(ready), .io_bit_sel_out(io_sel), .io_value_in(io_value),
        .status_flag_register_out(flags), .program_counter_out(pc), .done_out(done));
    // ==========================================================
    // Helpers
    function automatic logic [31:0] xs(input logic [31:0] x);
        x = x ^ (x << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_compared++;
        if (got !== exp) begin
            miscompares++;
            $display("mismatch at %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic end_sim();
        $display("compared %0d mismatched %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    // Flags of a subtraction, with Z chained for the carry form.
    task automatic model_cmp(input logic [7:0] d, input logic [7:0] s, input logic cin);
        logic [7:0] r;
        logic v;
        r = d - s - {7'h00, cin};
        v = (d[7] & ~s[7] & ~r[7]) | (~d[7] & s[7] & r[7]);
        ef[0] = (~d[7] & s[7]) | (s[7] & r[7]) | (r[7] & ~d[7]);
        ef[1] = (r == 8'h00) && (ef[1] || instr.op != csb_pkg::OP_COMPARE_CARRY);
        ef[2] = r[7];
        ef[3] = v;
        ef[4] = r[7] ^ v;
        ef[5] = (~d[3] & s[3]) | (s[3] & r[3]) | (r[3] & ~d[3]);
        epc = epc + 16'h0001;
    endtask
    // ==========================================================
    // Main sequence
    initial begin
        int cyc;
        int ecyc;
        logic hit;
        repeat (8) @(posedge clk_in);
        #1 reset_n_in = 1'b1;
        for (int i = 0; i < 400; i++) begin
            seed = xs(seed);
            if (seed[31]) begin
                // A withdrawn instruction must leave done low and the counter alone.
                instr.valid = 1'b0;
                @(posedge clk_in);
                #1 chk({15'h0000, done}, 16'h0000);
                chk(pc, epc);
            end
            instr.op = csb_pkg::csb_op_type'(seed[2:0]);
            instr.branch = (seed[2:0] == 3'h0);
            instr.next_is_two_word = seed[3];
            instr.bit_sel = seed[6:4];
            instr.offset = seed[13:7];
            instr.dest_value = seed[21:14];
            instr.source_value = seed[29:22];
            seed = xs(seed);
            instr.immediate = seed[7:0];
            io_value = seed[15:8];
            instr.valid = 1'b1;
            ecyc = 1;
            hit = 1'b0;
            case (instr.op)
                csb_pkg::OP_COMPARE: model_cmp(instr.dest_value, instr.source_value, 1'b0);
                csb_pkg::OP_COMPARE_CARRY: model_cmp(instr.dest_value, instr.source_value, ef[0]);
                csb_pkg::OP_COMPARE_IMM: model_cmp(instr.dest_value, instr.immediate, 1'b0);
                csb_pkg::OP_SKIP_REG_BIT_CLEAR: hit = !instr.source_value[instr.bit_sel];
                csb_pkg::OP_SKIP_REG_BIT_SET: hit = instr.source_value[instr.bit_sel];
                csb_pkg::OP_SKIP_IO_BIT_CLEAR: hit = !io_value[instr.bit_sel];
                csb_pkg::OP_SKIP_IO_BIT_SET: hit = io_value[instr.bit_sel];
                default: begin
                    epc = epc + 16'h0001;
                    if (ef[instr.bit_sel]) begin
                        epc = epc + {{9{instr.offset[6]}}, instr.offset};
                    end
                end
            endcase
            if (instr.op >= csb_pkg::OP_SKIP_REG_BIT_CLEAR) begin
                ecyc = hit ? (instr.next_is_two_word ? 3 : 2) : 1;
                epc = epc + 16'(ecyc);
            end
            @(posedge clk_in);
            #1 cyc = 1;
            chk({13'h0000, io_sel}, {13'h0000, instr.bit_sel});
            chk({15'h0000, ready}, {15'h0000, ecyc == 1});
            while (done !== 1'b1 && cyc <= 5) begin
                @(posedge clk_in);
                #1 cyc++;
            end
            if (done !== 1'b1) begin
                miscompares++;
                break;
            end
            chk(16'(cyc), 16'(ecyc));
            chk(pc, epc);
            chk({8'h00, flags}, {8'h00, ef});
        end
        $display("random instruction test done");
        end_sim();
    end
endmodule // tb_top
